/* rtl/mcsw_cmd_asm.sv */
`timescale 1ns/1ps
module mcsw_cmd_asm (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] byte_i,
	input wire logic byte_we_i,
	input wire logic restart_i,
	output mcsw_pkg::mcsw_tx_cfg_type tx_cfg_o,
	output mcsw_pkg::mcsw_rx_cfg_type rx_cfg_o,
	output logic tx_load_o,
	output logic rx_load_o,
	output logic rsv_err_o,
	output logic [1:0] idx_o
);
	typedef struct packed {
		logic [1:0] idx;
		logic [7:0] b0;
		logic [7:0] b1;
		mcsw_pkg::mcsw_tx_cfg_type tx;
		mcsw_pkg::mcsw_rx_cfg_type rx;
		logic tx_load;
		logic rx_load;
		logic rsv_err;
	} mcsw_cmd_state_type;

	mcsw_cmd_state_type st;
	mcsw_cmd_state_type next_st;
	logic [7:0] rsv_mask;

	// ------------------------------------------------------------
	// byte collection and decode
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.tx_load = 1'b0;
		next_st.rx_load = 1'b0;
		next_st.rsv_err = 1'b0;
		// reserved bits depend on the direction in the first byte
		if (((byte_we_i && st.idx == 2'h0) ? byte_i[0] : st.b0[0]) == mcsw_pkg::MCSW_DIR_RX) begin
			rsv_mask = mcsw_pkg::MCSW_RX_RSV[st.idx];
		end else begin
			rsv_mask = mcsw_pkg::MCSW_TX_RSV[st.idx];
		end
		if (restart_i) begin
			next_st.idx = 2'h0;
		end else if (byte_we_i) begin
			next_st.rsv_err = |(byte_i & rsv_mask);
			unique case (st.idx)
				2'h0: next_st.b0 = byte_i;
				2'h1: next_st.b1 = byte_i;
				default: ;
			endcase
			if (st.idx == mcsw_pkg::MCSW_LAST_BYTE) begin
				next_st.idx = 2'h0;
				if (st.b0[mcsw_pkg::MCSW_DIR_BIT] == mcsw_pkg::MCSW_DIR_TX) begin
					next_st.tx.mode = {1'b0, st.b0[mcsw_pkg::MCSW_MODE_HI:mcsw_pkg::MCSW_MODE_LO]};
					unique case (st.b0[mcsw_pkg::MCSW_SIG_HI:mcsw_pkg::MCSW_SIG_LO])
						mcsw_pkg::MCSW_SIG_550: next_st.tx.guard = mcsw_pkg::MCSW_GUARD_550;
						mcsw_pkg::MCSW_SIG_1800: next_st.tx.guard = mcsw_pkg::MCSW_GUARD_1800;
						default: next_st.tx.guard = mcsw_pkg::MCSW_GUARD_OFF;
					endcase
					next_st.tx.answer_originate_select = st.b0[mcsw_pkg::MCSW_ROLE_BIT];
					next_st.tx.attenuation = st.b1[mcsw_pkg::MCSW_ATTEN_HI:0];
					next_st.tx.scrambler_on = st.b1[mcsw_pkg::MCSW_SCRAMBLE_BIT];
					next_st.tx.rate_sel = st.b1[mcsw_pkg::MCSW_RATE_BIT];
					next_st.tx.param = byte_i[6:0];
					next_st.tx.tx_enable = byte_i[mcsw_pkg::MCSW_TX_EN_BIT];
					next_st.tx_load = 1'b1;
				end else begin
					next_st.rx.mode = {1'b0, st.b0[mcsw_pkg::MCSW_MODE_HI:mcsw_pkg::MCSW_MODE_LO]};
					next_st.rx.call_progress = (next_st.rx.mode == mcsw_pkg::MCSW_MODE_TONE);
					next_st.rx.ans_tone_sel = st.b0[mcsw_pkg::MCSW_ANS_TONE_BIT];
					next_st.rx.tx_sync = st.b0[mcsw_pkg::MCSW_TXSYNC_BIT];
					next_st.rx.cd_level = st.b0[mcsw_pkg::MCSW_CDLVL_BIT];
					next_st.rx.answer_originate_select = st.b0[mcsw_pkg::MCSW_ROLE_BIT];
					next_st.rx.descrambler_on = st.b1[mcsw_pkg::MCSW_SCRAMBLE_BIT];
					next_st.rx.rate_sel = st.b1[mcsw_pkg::MCSW_RATE_BIT];
					next_st.rx_load = 1'b1;
				end
			end else begin
				next_st.idx = st.idx + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tx_cfg_o = st.tx;
	assign rx_cfg_o = st.rx;
	assign tx_load_o = st.tx_load;
	assign rx_load_o = st.rx_load;
	assign rsv_err_o = st.rsv_err;
	assign idx_o = st.idx;
endmodule

/* rtl/mcsw_pkg.sv */
package mcsw_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] MCSW_ADR_CMD = 8'h00;
	localparam logic [7:0] MCSW_ADR_STATUS = 8'h04;
	localparam logic [7:0] MCSW_ADR_CTRL = 8'h08;
	localparam logic [7:0] MCSW_ADR_TXCFG = 8'h0c;
	localparam logic [7:0] MCSW_ADR_RXCFG = 8'h10;
	localparam logic [7:0] MCSW_ADR_IRQ_STAT = 8'h14;
	localparam logic [7:0] MCSW_ADR_IRQ_CLR = 8'h18;
	localparam logic [7:0] MCSW_ADR_IRQ_EN = 8'h1c;
	localparam logic [7:0] MCSW_ADR_STATE = 8'h20;

	// ------------------------------------------------------------
	// command and status field positions
	// ------------------------------------------------------------
	localparam int MCSW_DIR_BIT = 0;
	localparam int MCSW_MODE_LO = 1;
	localparam int MCSW_MODE_HI = 3;
	localparam int MCSW_SIG_LO = 4;
	localparam int MCSW_SIG_HI = 5;
	localparam int MCSW_ROLE_BIT = 7;
	localparam int MCSW_ATTEN_HI = 4;
	localparam int MCSW_SCRAMBLE_BIT = 5;
	localparam int MCSW_RATE_BIT = 7;
	localparam int MCSW_ANS_TONE_BIT = 4;
	localparam int MCSW_TXSYNC_BIT = 5;
	localparam int MCSW_CDLVL_BIT = 6;
	localparam int MCSW_TX_EN_BIT = 7;
	localparam int MCSW_CTRL_SEL_BIT = 0;
	localparam int MCSW_CTRL_RESTART_BIT = 1;
	localparam logic MCSW_DIR_TX = 1'b0;
	localparam logic MCSW_DIR_RX = 1'b1;

	// reserved bits per byte of each command word
	localparam logic [2:0][7:0] MCSW_TX_RSV = {8'h00, 8'h40, 8'h40};
	localparam logic [2:0][7:0] MCSW_RX_RSV = {8'hfe, 8'h5f, 8'h00};

	// mode codes
	localparam logic [3:0] MCSW_MODE_OFF = 4'h0;
	localparam logic [3:0] MCSW_MODE_V22BIS = 4'h1;
	localparam logic [3:0] MCSW_MODE_V22 = 4'h2;
	localparam logic [3:0] MCSW_MODE_B212 = 4'h3;
	localparam logic [3:0] MCSW_MODE_V23 = 4'h4;
	localparam logic [3:0] MCSW_MODE_V21 = 4'h5;
	localparam logic [3:0] MCSW_MODE_B103 = 4'h6;
	localparam logic [3:0] MCSW_MODE_TONE = 4'h7;

	// guard tone codes
	localparam logic [1:0] MCSW_SIG_OFF = 2'h0;
	localparam logic [1:0] MCSW_SIG_550 = 2'h1;
	localparam logic [1:0] MCSW_SIG_1800 = 2'h3;

	// word length, data bit counts, interrupt bits
	localparam logic [1:0] MCSW_LAST_BYTE = 2'h2;
	localparam int MCSW_QAM_BITS = 4;
	localparam int MCSW_DPSK_FAST_BITS = 2;
	localparam int MCSW_DPSK_SLOW_BITS = 1;
	localparam int MCSW_IRQ_W = 4;
	localparam int MCSW_IRQ_TX_CMD = 0;
	localparam int MCSW_IRQ_RX_CMD = 1;
	localparam int MCSW_IRQ_STAT = 2;
	localparam int MCSW_IRQ_RSV = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {MCSW_GUARD_OFF, MCSW_GUARD_550, MCSW_GUARD_1800} mcsw_guard_type;

	typedef struct packed {
		logic [3:0] mode;
		mcsw_guard_type guard;
		logic answer_originate_select;
		logic [4:0] attenuation;
		logic scrambler_on;
		logic rate_sel;
		logic [6:0] param;
		logic tx_enable;
	} mcsw_tx_cfg_type;

	typedef struct packed {
		logic [3:0] mode;
		logic call_progress;
		logic ans_tone_sel;
		logic tx_sync;
		logic cd_level;
		logic answer_originate_select;
		logic descrambler_on;
		logic rate_sel;
	} mcsw_rx_cfg_type;

	typedef struct packed {
		logic [3:0] raw_data;
		logic s1_seq;
		logic s1_or_cp;
		logic eq_ok;
		logic quality;
		logic carrier;
		logic [3:0] descr_data;
		logic [5:0] fsk_data;
		logic ans_tone;
	} mcsw_rx_stat_type;

endpackage

/* rtl/mcsw_stat_ser.sv */
`timescale 1ns/1ps
module mcsw_stat_ser (
	input wire logic clk_i,
	input wire logic rst_i,
	input mcsw_pkg::mcsw_rx_stat_type stat_i,
	input wire logic stat_we_i,
	input wire logic [3:0] mode_i,
	input wire logic rate_i,
	input wire logic sel_rx_i,
	input wire logic rd_adv_i,
	input wire logic restart_i,
	output logic [7:0] byte_o,
	output logic [1:0] idx_o,
	output logic loaded_o
);
	typedef struct packed {
		logic [1:0] idx;
		logic [2:0][7:0] word;
		mcsw_pkg::mcsw_rx_stat_type held;
		logic pending;
		logic loaded;
	} mcsw_stat_state_type;

	mcsw_stat_state_type st;
	mcsw_stat_state_type next_st;
	mcsw_pkg::mcsw_rx_stat_type src;
	logic [3:0] used;
	logic [3:0] raw_fill;
	logic [3:0] descr_fill;
	logic psk;
	int nbits;

	// ------------------------------------------------------------
	// word assembly, snapshot and byte pointer
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.loaded = 1'b0;
		src = stat_we_i ? stat_i : st.held;
		psk = (mode_i == mcsw_pkg::MCSW_MODE_V22BIS) || (mode_i == mcsw_pkg::MCSW_MODE_V22)
			|| (mode_i == mcsw_pkg::MCSW_MODE_B212);
		if (mode_i == mcsw_pkg::MCSW_MODE_V22BIS) begin
			nbits = mcsw_pkg::MCSW_QAM_BITS;
		end else if (rate_i) begin
			nbits = mcsw_pkg::MCSW_DPSK_SLOW_BITS;
		end else begin
			nbits = mcsw_pkg::MCSW_DPSK_FAST_BITS;
		end
		for (int i = 0; i < 4; i++) begin
			used[i] = !psk || (i < nbits);
		end
		raw_fill = src.raw_data | ~used;
		descr_fill = src.descr_data | ~used;
		if (stat_we_i) begin
			next_st.held = stat_i;
			next_st.pending = 1'b1;
		end
		if (restart_i) begin
			next_st.idx = 2'h0;
		end else if (rd_adv_i) begin
			next_st.idx = (st.idx == mcsw_pkg::MCSW_LAST_BYTE) ? 2'h0 : st.idx + 2'h1;
		end
		// refresh only between words; a read begun in the refresh cycle gets the old byte 0, then bytes 1 and 2 of the new snapshot
		if ((stat_we_i || st.pending) && st.idx == 2'h0 && !rd_adv_i) begin
			next_st.pending = 1'b0;
			next_st.loaded = 1'b1;
			next_st.word[0] = {src.s1_or_cp, src.s1_seq, 1'b0, raw_fill, mcsw_pkg::MCSW_DIR_RX};
			next_st.word[1] = {1'b0, src.carrier, src.quality, src.eq_ok, 4'h0};
			if (psk) begin
				next_st.word[2] = {src.ans_tone, 2'b11, descr_fill, 1'b0};
			end else begin
				next_st.word[2] = {src.ans_tone, src.fsk_data, 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// transmit status word carries only its direction bit
	assign byte_o = sel_rx_i ? st.word[st.idx] : {7'h00, mcsw_pkg::MCSW_DIR_TX};
	assign idx_o = st.idx;
	assign loaded_o = st.loaded;
endmodule

/* rtl/mcsw_top.sv */
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module mcsw_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input mcsw_pkg::mcsw_rx_stat_type stat_i,
	input wire logic stat_we_i,
	output mcsw_pkg::mcsw_tx_cfg_type tx_cfg_o,
	output mcsw_pkg::mcsw_rx_cfg_type rx_cfg_o,
	output logic tx_load_o,
	output logic rx_load_o,
	output logic irq_o
);
	// ------------------------------------------------------------
	// bus side state
	// ------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [mcsw_pkg::MCSW_IRQ_W-1:0] irq_stat;
		logic [mcsw_pkg::MCSW_IRQ_W-1:0] irq_en;
		logic sel_rx;
	} mcsw_bus_state_type;

	mcsw_bus_state_type st;
	mcsw_bus_state_type next_st;

	logic req;
	logic take;
	logic wr_lane0;
	logic cmd_we;
	logic stat_rd;
	logic restart;
	logic tx_load;
	logic rx_load;
	logic rsv_err;
	logic stat_loaded;
	logic [1:0] cmd_idx;
	logic [1:0] stat_idx;
	logic [7:0] stat_byte;
	logic [mcsw_pkg::MCSW_IRQ_W-1:0] events;
	logic [mcsw_pkg::MCSW_IRQ_W-1:0] clr;
	logic [31:0] rd_data;
	mcsw_pkg::mcsw_tx_cfg_type tx_cfg;
	mcsw_pkg::mcsw_rx_cfg_type rx_cfg;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// a request is answered one cycle after it appears; its side
	// effects happen at the edge where ack is high
	assign req = cyc_i && stb_i;
	assign take = req && st.ack;
	assign wr_lane0 = take && we_i && sel_i[0];
	assign cmd_we = wr_lane0 && (adr_i == mcsw_pkg::MCSW_ADR_CMD);
	assign stat_rd = take && !we_i && (adr_i == mcsw_pkg::MCSW_ADR_STATUS);
	assign restart = wr_lane0 && (adr_i == mcsw_pkg::MCSW_ADR_CTRL)
		&& dat_i[mcsw_pkg::MCSW_CTRL_RESTART_BIT];

	// ------------------------------------------------------------
	// command word collector
	// ------------------------------------------------------------
	mcsw_cmd_asm u_cmd (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.byte_i(dat_i[7:0]),
		.byte_we_i(cmd_we),
		.restart_i(restart),
		.tx_cfg_o(tx_cfg),
		.rx_cfg_o(rx_cfg),
		.tx_load_o(tx_load),
		.rx_load_o(rx_load),
		.rsv_err_o(rsv_err),
		.idx_o(cmd_idx)
	);

	// ------------------------------------------------------------
	// status word server
	// ------------------------------------------------------------
	mcsw_stat_ser u_stat (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.stat_i(stat_i),
		.stat_we_i(stat_we_i),
		.mode_i(rx_cfg.mode),
		.rate_i(rx_cfg.rate_sel),
		.sel_rx_i(st.sel_rx),
		.rd_adv_i(stat_rd),
		.restart_i(restart),
		.byte_o(stat_byte),
		.idx_o(stat_idx),
		.loaded_o(stat_loaded)
	);

	// ------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------
	always_comb begin
		events = '0;
		events[mcsw_pkg::MCSW_IRQ_TX_CMD] = tx_load;
		events[mcsw_pkg::MCSW_IRQ_RX_CMD] = rx_load;
		events[mcsw_pkg::MCSW_IRQ_STAT] = stat_loaded;
		events[mcsw_pkg::MCSW_IRQ_RSV] = rsv_err;
		clr = '0;
		if (wr_lane0 && adr_i == mcsw_pkg::MCSW_ADR_IRQ_CLR) begin
			clr = dat_i[mcsw_pkg::MCSW_IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// read data multiplexer
	// ------------------------------------------------------------
	always_comb begin
		rd_data = '0;
		unique case (adr_i)
			mcsw_pkg::MCSW_ADR_STATUS: rd_data = {24'h000000, stat_byte};
			mcsw_pkg::MCSW_ADR_CTRL: rd_data = {31'h00000000, st.sel_rx};
			mcsw_pkg::MCSW_ADR_TXCFG: rd_data = 32'(tx_cfg);
			mcsw_pkg::MCSW_ADR_RXCFG: rd_data = 32'(rx_cfg);
			mcsw_pkg::MCSW_ADR_IRQ_STAT: rd_data = 32'(st.irq_stat);
			mcsw_pkg::MCSW_ADR_IRQ_EN: rd_data = 32'(st.irq_en);
			mcsw_pkg::MCSW_ADR_STATE: rd_data = {28'h0000000, stat_idx, cmd_idx};
			default: rd_data = '0;
		endcase
	end

	// ------------------------------------------------------------
	// next state of the bus side
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// ack rises one cycle after the request and falls the cycle after
		next_st.ack = req && !st.ack;
		if (req && !st.ack) begin
			next_st.dat = we_i ? 32'h00000000 : rd_data;
		end
		if (wr_lane0 && adr_i == mcsw_pkg::MCSW_ADR_CTRL) begin
			next_st.sel_rx = dat_i[mcsw_pkg::MCSW_CTRL_SEL_BIT];
		end
		if (wr_lane0 && adr_i == mcsw_pkg::MCSW_ADR_IRQ_EN) begin
			next_st.irq_en = dat_i[mcsw_pkg::MCSW_IRQ_W-1:0];
		end
		// a new event wins over a clear in the same cycle
		next_st.irq_stat = (st.irq_stat & ~clr) | events;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign tx_cfg_o = tx_cfg;
	assign rx_cfg_o = rx_cfg;
	assign tx_load_o = tx_load;
	assign rx_load_o = rx_load;
	assign irq_o = |(st.irq_stat & st.irq_en);
endmodule

/* sim/mcsw_host_model.sv */
`timescale 1ns/1ps
module mcsw_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// bus idle at time zero
	initial begin
		cyc_o = 1'h0;
		stb_o = 1'h0;
		we_o = 1'h0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	// one classic cycle, request held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'h1;
		stb_o <= 1'h1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'h1);
		q = dat_i;
		cyc_o <= 1'h0;
		stb_o <= 1'h0;
		// released lines show the inverse of the last value
		we_o <= ~w;
		adr_o <= ~a;
		sel_o <= 4'h0;
		dat_o <= ~d;
	endtask
	// a command word: reserved bits cleared, bytes in order
	task automatic cmd_word(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		logic [2:0][7:0] m;
		logic [31:0] q;
		m = b0[0] ? mcsw_pkg::MCSW_RX_RSV : mcsw_pkg::MCSW_TX_RSV;
		xfer(1'h1, mcsw_pkg::MCSW_ADR_CMD, {24'h0, b0 & ~m[0]}, q);
		xfer(1'h1, mcsw_pkg::MCSW_ADR_CMD, {24'h0, b1 & ~m[1]}, q);
		xfer(1'h1, mcsw_pkg::MCSW_ADR_CMD, {24'h0, b2 & ~m[2]}, q);
	endtask
endmodule

/* sim/mcsw_top_sva.sv */
`timescale 1ns/1ps
module mcsw_top_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input mcsw_pkg::mcsw_rx_stat_type stat_i,
	input wire logic stat_we_i,
	input mcsw_pkg::mcsw_tx_cfg_type tx_cfg_o,
	input mcsw_pkg::mcsw_rx_cfg_type rx_cfg_o,
	input wire logic tx_load_o,
	input wire logic rx_load_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// command byte tracking
	// ------------------------------------------------------------
	logic wr_any;
	logic [1:0] idx;
	logic [7:0] b0;
	logic [7:0] b1;
	logic done;
	mcsw_pkg::mcsw_guard_type gd;
	// a write takes effect at the edge that samples ack
	assign wr_any = cyc_i && stb_i && we_i && ack_o && sel_i[0];
	assign gd = (b0[5:4] == 2'h1) ? mcsw_pkg::MCSW_GUARD_550 :
		(b0[5:4] == 2'h3) ? mcsw_pkg::MCSW_GUARD_1800 : mcsw_pkg::MCSW_GUARD_OFF;
	// byte pointer, first two bytes, word completion
	always_ff @(posedge clk_i) begin
		done <= !rst_i && wr_any && adr_i == mcsw_pkg::MCSW_ADR_CMD && idx == 2'h2;
		if (rst_i) begin
			idx <= 2'h0;
		end else if (wr_any && adr_i == mcsw_pkg::MCSW_ADR_CMD) begin
			idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
			if (idx == 2'h0) b0 <= dat_i[7:0];
			if (idx == 2'h1) b1 <= dat_i[7:0];
		end else if (wr_any && adr_i == mcsw_pkg::MCSW_ADR_CTRL && dat_i[1]) begin
			idx <= 2'h0;
		end
	end
	sequence s_third;
		wr_any && adr_i == mcsw_pkg::MCSW_ADR_CMD && idx == 2'h2;
	endsequence
	sequence s_tx;
		s_third ##0 !b0[0];
	endsequence
	sequence s_rx;
		s_third ##0 b0[0];
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered in one cycle");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_load_dir: assert property (
		s_third |=> tx_load_o == !b0[0] && rx_load_o == b0[0])
		else $error("load pulse of wrong direction");
	a_load_cause: assert property ((tx_load_o || rx_load_o) |-> done)
		else $error("load without a complete word");
	a_cfg_steady: assert property (!tx_load_o |-> $stable(tx_cfg_o))
		else $error("transmit config changed without load");
	a_rx_steady: assert property (!rx_load_o |-> $stable(rx_cfg_o))
		else $error("receive config changed without load");
	a_tx_mode: assert property (s_tx |=> tx_cfg_o.mode == {1'h0, b0[3:1]})
		else $error("transmit mode decode");
	a_tx_guard: assert property (
		s_tx |=> tx_cfg_o.guard == gd && tx_cfg_o.answer_originate_select == b0[7])
		else $error("guard tone or role decode");
	a_tx_second: assert property (
		s_tx |=> {tx_cfg_o.rate_sel, tx_cfg_o.scrambler_on, tx_cfg_o.attenuation} ==
		{b1[7], b1[5:0]})
		else $error("transmit second byte decode");
	a_rx_mode: assert property (s_rx |=> rx_cfg_o.mode == {1'h0, b0[3:1]} &&
		rx_cfg_o.call_progress == (b0[3:1] == 3'h7))
		else $error("receive mode decode");
	a_rx_first: assert property (s_rx |=> {rx_cfg_o.answer_originate_select,
		rx_cfg_o.cd_level, rx_cfg_o.tx_sync, rx_cfg_o.ans_tone_sel} == b0[7:4])
		else $error("receive first byte decode");
	a_rx_second: assert property (
		s_rx |=> {rx_cfg_o.rate_sel, rx_cfg_o.descrambler_on} == {b1[7], b1[5]})
		else $error("receive second byte decode");
endmodule
bind mcsw_top mcsw_top_sva mcsw_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .stat_i(stat_i), .stat_we_i(stat_we_i),
	.tx_cfg_o(tx_cfg_o), .rx_cfg_o(rx_cfg_o), .tx_load_o(tx_load_o),
	.rx_load_o(rx_load_o), .irq_o(irq_o));

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk, rst, cyc, stb, we, ack, stat_we, tx_load, rx_load, irq;
	logic [7:0] adr, r8;
	logic [3:0] sel, exp_irq;
	logic [31:0] dat_w, dat_r, rd;
	mcsw_pkg::mcsw_rx_stat_type stat;
	mcsw_pkg::mcsw_tx_cfg_type tx_cfg;
	mcsw_pkg::mcsw_rx_cfg_type rx_cfg;
	logic [7:0] q[$];
	logic [7:0] regs[7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h24};
	int n_fail = 0;
	int samples_checked = 0;
	int i;
	mcsw_top mcsw_top_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .stat_i(stat),
		.stat_we_i(stat_we), .tx_cfg_o(tx_cfg), .rx_cfg_o(rx_cfg), .tx_load_o(tx_load),
		.rx_load_o(rx_load), .irq_o(irq));
	mcsw_host_model mcsw_host_model_inst (.clk_i(clk), .ack_i(ack), .dat_i(dat_r),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dat_w));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task finish_test;
		if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		mcsw_host_model_inst.xfer(1'h1, a, d, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		mcsw_host_model_inst.xfer(1'h0, a, 32'h0, rd);
		chk(rd, e);
	endtask
	task automatic irq_chk(input logic e);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// send a word, then compare load pulse and decoded config with the model
	task automatic send_cmd(input logic [7:0] b0, b1, b2, input logic bad);
		logic [7:0] c[3];
		logic [2:0][7:0] m;
		mcsw_pkg::mcsw_tx_cfg_type et;
		mcsw_pkg::mcsw_rx_cfg_type er;
		int k;
		c = '{b0, b1, b2};
		m = b0[0] ? mcsw_pkg::MCSW_RX_RSV : mcsw_pkg::MCSW_TX_RSV;
		for (k = 0; k < 3; k++) begin
			if (!bad) c[k] &= ~m[k];
			else if ((c[k] & m[k]) != 8'h00) exp_irq[3] = 1'h1;
		end
		if (bad) for (k = 0; k < 3; k++) wr(mcsw_pkg::MCSW_ADR_CMD, {24'h0, c[k]});
		else mcsw_host_model_inst.cmd_word(c[0], c[1], c[2]);
		k = 0;
		while (!(tx_load || rx_load) && k < 8) begin
			@(negedge clk);
			k++;
		end
		chk({30'h0, rx_load, tx_load}, b0[0] ? 32'h2 : 32'h1);
		exp_irq[b0[0]] = 1'h1;
		et = '0;
		et.mode = {1'h0, c[0][3:1]};
		et.guard = (c[0][5:4] == 2'h1) ? mcsw_pkg::MCSW_GUARD_550 :
			(c[0][5:4] == 2'h3) ? mcsw_pkg::MCSW_GUARD_1800 : mcsw_pkg::MCSW_GUARD_OFF;
		et.answer_originate_select = c[0][7];
		{et.rate_sel, et.scrambler_on, et.attenuation} = {c[1][7], c[1][5:0]};
		{et.tx_enable, et.param} = c[2];
		er = '0;
		er.mode = {1'h0, c[0][3:1]};
		er.call_progress = (c[0][3:1] == 3'h7);
		{er.answer_originate_select, er.cd_level, er.tx_sync, er.ans_tone_sel} = c[0][7:4];
		{er.rate_sel, er.descrambler_on} = {c[1][7], c[1][5]};
		if (b0[0]) chk(32'(rx_cfg), 32'(er));
		else chk(32'(tx_cfg), 32'(et));
	endtask
	// offer one snapshot and queue the status word that the rules expect
	task automatic offer(input logic [3:0] m, input logic r);
		logic [3:0] f;
		logic [7:0] b2;
		@(posedge clk);
		stat <= 20'($urandom);
		stat_we <= 1'h1;
		@(posedge clk);
		stat_we <= 1'h0;
		repeat (3) @(posedge clk);
		f = (m == 4'h2 || m == 4'h3) ? (r ? 4'he : 4'hc) : 4'h0;
		b2 = (m >= 4'h1 && m <= 4'h3) ? {stat.ans_tone, 2'h3, stat.descr_data | f, 1'h0} :
			{stat.ans_tone, stat.fsk_data, 1'h0};
		q.push_back({stat.s1_or_cp, stat.s1_seq, 1'h0, stat.raw_data | f, 1'h1});
		q.push_back({1'h0, stat.carrier, stat.quality, stat.eq_ok, 4'h0});
		q.push_back(b2);
		exp_irq[2] = 1'h1;
	endtask
	// set a receive mode and read status words back; with mid, a second
	// snapshot offered after the first byte must wait for the word's end
	task automatic stat_chk(input logic [3:0] m, input logic r, input logic mid);
		send_cmd({4'h0, m[2:0], 1'h1}, {r, 7'h20}, 8'h00, 1'h0);
		offer(m, r);
		if (mid) begin
			rd_chk(mcsw_pkg::MCSW_ADR_STATUS, {24'h0, q.pop_front()});
			offer(m, r);
		end
		while (q.size() > 0) rd_chk(mcsw_pkg::MCSW_ADR_STATUS, {24'h0, q.pop_front()});
	endtask
	// ------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h5076fd42));
		rst <= 1'h1;
		stat <= '0;
		stat_we <= 1'h0;
		exp_irq = 4'h0;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		for (i = 0; i < 7; i++) rd_chk(regs[i], 32'h0);
		wr(mcsw_pkg::MCSW_ADR_IRQ_EN, 32'hf);
		for (i = 0; i < 8; i++) begin
			r8 = 8'($urandom);
			send_cmd({r8[7:6], i[1:0], i[2:0], 1'h0}, 8'($urandom), 8'($urandom), 1'h0);
			send_cmd({r8[7:4], i[2:0], 1'h1}, 8'($urandom), 8'($urandom), 1'h0);
		end
		rd_chk(mcsw_pkg::MCSW_ADR_IRQ_STAT, {28'h0, exp_irq});
		irq_chk(1'h1);
		wr(mcsw_pkg::MCSW_ADR_IRQ_EN, 32'h0);
		irq_chk(1'h0);
		wr(mcsw_pkg::MCSW_ADR_IRQ_EN, 32'hf);
		wr(mcsw_pkg::MCSW_ADR_IRQ_CLR, 32'hf);
		exp_irq = 4'h0;
		rd_chk(mcsw_pkg::MCSW_ADR_IRQ_STAT, 32'h0);
		irq_chk(1'h0);
		send_cmd(8'h40, 8'h40, 8'h00, 1'h1);
		rd_chk(mcsw_pkg::MCSW_ADR_IRQ_STAT, {28'h0, exp_irq});
		wr(mcsw_pkg::MCSW_ADR_CMD, 32'h1);
		wr(mcsw_pkg::MCSW_ADR_CMD, 32'h80);
		wr(mcsw_pkg::MCSW_ADR_CTRL, 32'h2);
		send_cmd(8'($urandom) & 8'hfe, 8'($urandom), 8'($urandom), 1'h0);
		wr(mcsw_pkg::MCSW_ADR_CTRL, 32'h1);
		for (i = 0; i < 10; i++) stat_chk((i < 8) ? i[3:0] : i[3:0] - 4'h6, i >= 8, i[0]);
		wr(mcsw_pkg::MCSW_ADR_CTRL, 32'h0);
		for (i = 0; i < 3; i++) rd_chk(mcsw_pkg::MCSW_ADR_STATUS, 32'h0);
		rd_chk(mcsw_pkg::MCSW_ADR_IRQ_STAT, {28'h0, exp_irq});
		irq_chk(1'h1);
		finish_test;
	end
endmodule
